//--- cba_pkg.sv
package cba_pkg;
    // Cluster geometry
    localparam int NUM_PROC = 8;
    localparam int ID_W     = 3;
    localparam int ADDR_W   = 32;
    localparam int DATA_W   = 64;
    localparam int HALF_W   = 32;
    localparam int QUAD_W   = 128;
    localparam int WS_W     = 3;
    localparam int BEAT_W   = 3;

    // Multiprocessor address decode
    localparam int MP_HDR_HI = 31;
    localparam int MP_HDR_LO = 26;
    localparam int MP_FLD_HI = 25;
    localparam int MP_FLD_LO = 22;
    localparam int VIRQ_BIT  = 21;
    localparam logic [3:0] PROCESSOR_ID_FIELD_BCAST = 4'h7;
    localparam logic [MP_HDR_HI-MP_HDR_LO:0] MP_HDR_VAL = 6'h00;

    // Slave memory window, one 64-bit word per even word address
    localparam int MEM_AW    = 6;
    localparam int MEM_WORDS = 64;

    // Address steps in 32-bit words per beat
    localparam logic [3:0] STEP_NARROW = 4'h1;
    localparam logic [3:0] STEP_WIDE   = 4'h2;

    // Core transfer sizes
    localparam logic [1:0] SZ_32  = 2'h0;
    localparam logic [1:0] SZ_64  = 2'h1;
    localparam logic [1:0] SZ_128 = 2'h2;

    typedef enum {M_IDLE, M_ARB, M_ADDR, M_WAIT, M_DATA} cba_mst_e;
endpackage : cba_pkg

//--- cba_addr_cnt.sv
// Burst address counter: loads a first address and steps it per beat
module cba_addr_cnt
    import cba_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              set_in,
    input  wire logic [ADDR_W-1:0] set_val_in,
    input  wire logic              inc_in,
    input  wire logic [3:0]        step_in,
    output logic      [ADDR_W-1:0] value_out
);
    // Set wins over increment so a new burst never inherits a stale address
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            value_out <= 32'h0000_0000;
        end else if (set_in) begin
            value_out <= set_val_in;
        end else if (inc_in) begin
            value_out <= value_out + ADDR_W'(step_in);
        end
    end
endmodule : cba_addr_cnt

//--- cba_pack.sv
// Packs 32- or 64-bit bus beats into one 128-bit internal word
module cba_pack
    import cba_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              clr_in,
    input  wire logic              load_in,
    input  wire logic              wide_in,
    input  wire logic [DATA_W-1:0] beat_in,
    output logic      [QUAD_W-1:0] quad_out
);
    logic [1:0] pos;

    // Beats land from the low end upward; narrow beats use the low lane
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pos      <= 2'h0;
            quad_out <= '0;
        end else if (clr_in) begin
            pos      <= 2'h0;
            quad_out <= '0;
        end else if (load_in) begin
            if (wide_in) begin
                quad_out[pos[0]*DATA_W +: DATA_W] <= beat_in;
            end else begin
                quad_out[pos*HALF_W +: HALF_W] <= beat_in[HALF_W-1:0];
            end
            pos <= pos + 2'h1;
        end
    end
endmodule : cba_pack

//--- cba_arbiter.sv
// What this block does
// - Distributed arbitration lets eight processors and a host share the bus gluelessly.
// - Processors rotate ownership round-robin; a host request beats every processor except an owner still holding the bus.
// - A locked owner keeps the bus so read and write stay indivisible.
// - Host grant is returned once the current master gives up the bus.
// - Host transfers are synchronous, pipelined, and may be stretched by wait cycles.
// - Host and peers can read and write internal memory and resources.
// - Broadcast-region writes reach every processor in the same cycle.
// - In a burst the slave latches the first address and increments it.
// - One external bus, 32-bit address and 64-bit data; 32/64-bit devices.
// - External data is packed into 32-, 64- or 128-bit internal words.
// - Core stalls when it uses a read target before the data arrives.
// - Programmable wait states serve peripherals with differing timing.
// - Bus runs pipelined normally; an asynchronous mode serves slow devices.
// - Vector interrupts from other masters, including host, are accepted.
// - Processor identifier 0 to 7 selects the target in multiprocessor space.
module cba_arbiter
    import cba_pkg::*;
(
    input  wire logic                REF_CLK_IN,
    input  wire logic                RESET_N_IN,
    input  wire logic [ID_W-1:0]     PROC_ID_IN,
    input  wire logic [NUM_PROC-1:0] BUS_REQ_N_IN,
    output logic                     BUS_REQ_N_OUT,
    input  wire logic                HOST_BUS_REQUEST_N_IN,
    output logic                     HOST_BUS_GRANT_N_OUT,
    input  wire logic                LOCK_IN,
    input  wire logic [ADDR_W-1:0]   ADDR_IN,
    output logic      [ADDR_W-1:0]   ADDR_OUT,
    output logic                     ADDR_OE_N_OUT,
    input  wire logic [DATA_W-1:0]   DATA_IN,
    output logic      [DATA_W-1:0]   DATA_OUT,
    output logic                     DATA_OE_N_OUT,
    input  wire logic                WR_N_IN,
    input  wire logic                RD_N_IN,
    output logic                     WR_N_OUT,
    output logic                     RD_N_OUT,
    output logic                     CTRL_OE_N_OUT,
    input  wire logic                BURST_INDICATOR_N_IN,
    output logic                     BURST_INDICATOR_N_OUT,
    input  wire logic [WS_W-1:0]     WAIT_STATES_IN,
    input  wire logic                ASYNC_MODE_IN,
    input  wire logic                SLOW_ACK_IN,
    input  wire logic                CORE_RD_IN,
    input  wire logic                CORE_WR_IN,
    input  wire logic [1:0]          CORE_SIZE_IN,
    input  wire logic                CORE_WIDE_DEV_IN,
    input  wire logic [ADDR_W-1:0]   CORE_ADDR_IN,
    input  wire logic [QUAD_W-1:0]   CORE_WDATA_IN,
    input  wire logic                CORE_USE_IN,
    output logic                     CORE_BUSY_OUT,
    output logic                     CORE_STALL_OUT,
    output logic      [QUAD_W-1:0]   CORE_RDATA_OUT,
    output logic                     CORE_RDATA_VALID_OUT,
    output logic                     VEC_IRQ_OUT,
    output logic      [HALF_W-1:0]   VEC_DATA_OUT
);
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    logic [ID_W-1:0]     my_id;
    logic                id_taken;
    logic [NUM_PROC-1:0] req;
    logic                host_req;
    logic [ID_W-1:0]     owner;
    logic                busy;
    logic                host_owns;
    logic                owner_holds;
    logic                my_grant;
    logic                own_turn;
    cba_mst_e            mst;
    logic                rd_q;
    logic                wide_q;
    logic                async_q;
    logic [WS_W-1:0]     ws_q;
    logic [WS_W-1:0]     wcnt;
    logic [BEAT_W-1:0]   beats;
    logic [BEAT_W-1:0]   bidx;
    logic                last_beat;
    logic [QUAD_W-1:0]   wdata_q;
    logic                rd_pend;
    logic                slv_act;
    logic                slv_cont;
    logic [ADDR_W-1:0]   slv_base;
    logic [ADDR_W-1:0]   slv_eff;
    logic [3:0]          slv_fld;
    logic                slv_hdr;
    logic                slv_wr_hit;
    logic                slv_rd_hit;
    logic [MEM_AW-1:0]   slv_idx;
    logic [DATA_W-1:0]   mem [MEM_WORDS];

    // Lowest-distance requester after the last owner wins the next turn
    function automatic logic [ID_W-1:0] rr_pick(input logic [NUM_PROC-1:0] r,
                                                input logic [ID_W-1:0]     last);
        logic [ID_W-1:0] pick;
        logic [ID_W-1:0] j;
        pick = last;
        for (int i = NUM_PROC; i >= 1; i--) begin
            j = last + ID_W'(i);
            if (r[j]) pick = j;
        end
        return pick;
    endfunction : rr_pick

    // Identifier strap is caught after reset release, never under reset
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            my_id    <= 3'h0;
            id_taken <= 1'b0;
        end else if (!id_taken) begin
            my_id    <= PROC_ID_IN;
            id_taken <= 1'b1;
        end
    end

    assign req         = ~BUS_REQ_N_IN;
    assign host_req    = !HOST_BUS_REQUEST_N_IN;
    assign owner_holds = busy && req[owner];
    // Lock keys off our turn, not our looped-back line, so no combinational loop forms
    assign own_turn    = busy && !host_owns && (owner == my_id);
    assign my_grant    = own_turn && req[my_id];

    // Every processor runs this same state on the shared request lines, so all agree
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            owner     <= 3'h0;
            busy      <= 1'b0;
            host_owns <= 1'b0;
        end else if (host_owns) begin
            if (!host_req) host_owns <= 1'b0;
        end else if (host_req && !owner_holds) begin
            host_owns <= 1'b1;
            busy      <= 1'b0;
        end else if (!owner_holds) begin
            busy  <= |req;
            owner <= rr_pick(req, owner);
        end
    end

    // Grant stays with the host for its whole tenure, external memory included
    assign HOST_BUS_GRANT_N_OUT = !host_owns;

    // Own request: dropped while waiting if the host asks, held across a lock
    assign BUS_REQ_N_OUT = !((mst == M_ARB && !(host_req && !LOCK_IN)) ||
                             mst == M_ADDR || mst == M_WAIT || mst == M_DATA ||
                             (LOCK_IN && own_turn));

    assign last_beat = (bidx == beats - BEAT_W'(1));

    // Master sequencer: arbitration, address phase, wait phase, data phase
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            mst <= M_IDLE;
            wcnt <= 3'h0;
            bidx <= 3'h0;
        end else begin
            unique case (mst)
                M_IDLE: begin
                    bidx <= 3'h0;
                    if (CORE_RD_IN || CORE_WR_IN) mst <= M_ARB;
                end
                M_ARB: begin
                    if (my_grant) mst <= M_ADDR;
                end
                M_ADDR: begin
                    wcnt <= ws_q;
                    mst  <= (async_q || ws_q != 3'h0) ? M_WAIT : M_DATA;
                end
                M_WAIT: begin
                    if (async_q) begin
                        if (SLOW_ACK_IN) mst <= M_DATA;
                    end else if (wcnt == 3'h1) begin
                        mst <= M_DATA;
                    end else begin
                        wcnt <= wcnt - 3'h1;
                    end
                end
                M_DATA: begin
                    bidx <= bidx + 3'h1;
                    mst  <= last_beat ? M_IDLE : M_ADDR;
                end
            endcase
        end
    end

    // Request capture; beats per transfer depend on size and device width
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rd_q    <= 1'b0;
            wide_q  <= 1'b0;
            async_q <= 1'b0;
            ws_q    <= 3'h0;
            beats   <= 3'h1;
            wdata_q <= '0;
        end else if (mst == M_IDLE && (CORE_RD_IN || CORE_WR_IN)) begin
            rd_q    <= CORE_RD_IN;
            wide_q  <= CORE_WIDE_DEV_IN;
            async_q <= ASYNC_MODE_IN;
            ws_q    <= WAIT_STATES_IN;
            wdata_q <= CORE_WDATA_IN;
            if (CORE_SIZE_IN == SZ_32) begin
                beats <= 3'h1;
            end else begin
                beats <= (3'h1 << CORE_SIZE_IN) >> CORE_WIDE_DEV_IN;
            end
        end
    end

    // Beat address for the master side
    cba_addr_cnt u_mst_addr (
        .clk_in     (REF_CLK_IN),
        .rst_n_in   (RESET_N_IN),
        .set_in     (mst == M_IDLE && (CORE_RD_IN || CORE_WR_IN)),
        .set_val_in (CORE_ADDR_IN),
        .inc_in     (mst == M_DATA && !last_beat),
        .step_in    (wide_q ? STEP_WIDE : STEP_NARROW),
        .value_out  (ADDR_OUT)
    );

    // Strobes and burst mark in the address cycle only, pipelined style
    assign ADDR_OE_N_OUT         = !(mst == M_ADDR);
    assign CTRL_OE_N_OUT         = !(mst == M_ADDR);
    assign WR_N_OUT              = !(mst == M_ADDR && !rd_q);
    assign RD_N_OUT              = !(mst == M_ADDR && rd_q);
    assign BURST_INDICATOR_N_OUT = !(mst == M_ADDR && !last_beat);
    assign CORE_BUSY_OUT         = (mst != M_IDLE);

    // Read beats fill the packer; it clears when a new read request is taken
    cba_pack u_pack (
        .clk_in   (REF_CLK_IN),
        .rst_n_in (RESET_N_IN),
        .clr_in   (mst == M_IDLE && CORE_RD_IN),
        .load_in  (mst == M_DATA && rd_q),
        .wide_in  (wide_q),
        .beat_in  (DATA_IN),
        .quad_out (CORE_RDATA_OUT)
    );

    // Outstanding read tracking; the core waits on it instead of a fixed latency
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rd_pend              <= 1'b0;
            CORE_RDATA_VALID_OUT <= 1'b0;
        end else begin
            CORE_RDATA_VALID_OUT <= (mst == M_DATA && last_beat && rd_q);
            if (mst == M_IDLE && CORE_RD_IN) begin
                rd_pend <= 1'b1;
            end else if (mst == M_DATA && last_beat) begin
                rd_pend <= 1'b0;
            end
        end
    end

    assign CORE_STALL_OUT = CORE_USE_IN && rd_pend;

    // Slave side: a burst continuation beat takes no address from the bus
    assign slv_act = !WR_N_IN || !RD_N_IN;
    assign slv_eff = slv_cont ? slv_base + ADDR_W'(STEP_WIDE) : ADDR_IN;

    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            slv_cont <= 1'b0;
        end else begin
            slv_cont <= slv_act && !BURST_INDICATOR_N_IN;
        end
    end

    cba_addr_cnt u_slv_addr (
        .clk_in     (REF_CLK_IN),
        .rst_n_in   (RESET_N_IN),
        .set_in     (slv_act && !slv_cont),
        .set_val_in (ADDR_IN),
        .inc_in     (slv_act && slv_cont),
        .step_in    (STEP_WIDE),
        .value_out  (slv_base)
    );

    // Decode own slot or broadcast; broadcast is write-only
    assign slv_hdr    = (slv_eff[MP_HDR_HI:MP_HDR_LO] == MP_HDR_VAL);
    assign slv_fld    = slv_eff[MP_FLD_HI:MP_FLD_LO];
    assign slv_idx    = slv_eff[MEM_AW:1];
    assign slv_wr_hit = !WR_N_IN && slv_hdr &&
                        (slv_fld == {1'b1, my_id} || slv_fld == PROCESSOR_ID_FIELD_BCAST);
    assign slv_rd_hit = !RD_N_IN && slv_hdr && (slv_fld == {1'b1, my_id});

    // Internal memory window; no reset so it maps to plain storage
    always_ff @(posedge REF_CLK_IN) begin
        if (slv_wr_hit && !slv_eff[VIRQ_BIT]) begin
            mem[slv_idx] <= DATA_IN;
        end
    end

    // Vector interrupt from any master, host included
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            VEC_IRQ_OUT  <= 1'b0;
            VEC_DATA_OUT <= 32'h0000_0000;
        end else begin
            VEC_IRQ_OUT <= slv_wr_hit && slv_eff[VIRQ_BIT];
            if (slv_wr_hit && slv_eff[VIRQ_BIT]) VEC_DATA_OUT <= DATA_IN[HALF_W-1:0];
        end
    end

    // Data lanes: master write beat or slave read answer, one cycle after address
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            DATA_OUT      <= '0;
            DATA_OE_N_OUT <= 1'b1;
        end else begin
            DATA_OE_N_OUT <= !((!rd_q && (mst == M_ADDR || mst == M_WAIT)) ||
                               slv_rd_hit);
            if (slv_rd_hit) begin
                DATA_OUT <= mem[slv_idx];
            end else if (mst == M_ADDR && !rd_q) begin
                if (wide_q) begin
                    DATA_OUT <= wdata_q[bidx[0]*DATA_W +: DATA_W];
                end else begin
                    DATA_OUT <= {32'h0000_0000, wdata_q[bidx[1:0]*HALF_W +: HALF_W]};
                end
            end
        end
    end

    // Checks
    chk_host_wins: assert property ((host_req && !host_owns && !owner_holds)
        |=> !HOST_BUS_GRANT_N_OUT) else $error("host not granted");
    chk_grant_cause: assert property ($fell(HOST_BUS_GRANT_N_OUT)
        |-> $past(host_req) && !$past(owner_holds)) else $error("grant without cause");
    chk_grant_drop: assert property ((host_owns && !host_req)
        |=> HOST_BUS_GRANT_N_OUT) else $error("grant not withdrawn");
    chk_lock_hold: assert property ((my_grant && LOCK_IN)
        |-> !BUS_REQ_N_OUT) else $error("locked bus released");
    chk_rr_rotate: assert property ((busy && !host_owns && !host_req && !req[owner] && |req)
        |=> busy && owner != $past(owner)) else $error("ownership did not rotate");
    chk_bcast_write: assert property ((slv_wr_hit && !slv_eff[VIRQ_BIT])
        |=> mem[$past(slv_idx)] == $past(DATA_IN)) else $error("write lost");
    chk_burst_incr: assert property ((slv_act && !BURST_INDICATOR_N_IN) ##1 slv_act
        |-> slv_eff == $past(slv_eff) + 32'h0000_0002) else $error("burst address wrong");
    chk_wait_count: assert property ((mst == M_ADDR && !async_q && ws_q == 3'h2)
        |=> (mst == M_WAIT)[*2] ##1 mst == M_DATA) else $error("wait count wrong");
    chk_read_done: assert property ((mst == M_DATA && last_beat && rd_q)
        |=> CORE_RDATA_VALID_OUT && !CORE_STALL_OUT) else $error("read not delivered");
    chk_vector_irq: assert property ((slv_wr_hit && slv_eff[VIRQ_BIT])
        |=> VEC_IRQ_OUT && VEC_DATA_OUT == $past(DATA_IN[HALF_W-1:0]))
        else $error("vector irq not raised");
    chk_irq_quiet: assert property (!(slv_wr_hit && slv_eff[VIRQ_BIT])
        |=> !VEC_IRQ_OUT) else $error("vector irq without write");
endmodule : cba_arbiter

//--- cba_far_model.sv
// Far side of the cluster bus: a memory that answers our own master beats,
// quickly or slowly, and records the last word we wrote to it
module cba_far_model
    import cba_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              addr_oe_n_in,
    input  wire logic              rd_n_in,
    input  wire logic              wr_n_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] data_in,
    input  wire logic [WS_W-1:0]   ws_in,
    output logic                   ack_out,
    output logic      [DATA_W-1:0] data_out,
    output logic      [ADDR_W-1:0] wr_addr_out,
    output logic      [DATA_W-1:0] wr_data_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [ADDR_W-1:0] lat;
    logic [4:0]        cnt;
    logic              is_wr;
    logic              tgl;

    // Each address cycle opens a beat; the count saturates when idle
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lat   <= '0;
            cnt   <= 5'h1f;
            is_wr <= 1'b0;
        end else if (!addr_oe_n_in && !(rd_n_in && wr_n_in)) begin
            lat   <= addr_in;
            cnt   <= 5'h00;
            is_wr <= !wr_n_in;
        end else if (cnt != 5'h1f) begin
            cnt <= cnt + 5'h01;
        end
    end

    // Toggles every cycle so a released bus never looks stable
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tgl <= 1'b0;
        end else begin
            tgl <= !tgl;
        end
    end

    // Write data is taken in the data cycle after the wait cycles
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_addr_out <= '0;
            wr_data_out <= '0;
        end else if (is_wr && cnt == {2'h0, ws_in}) begin
            wr_addr_out <= lat;
            wr_data_out <= data_in;
        end
    end

    // Slow device answers three cycles into the beat
    assign ack_out = (cnt >= 5'h03) && (cnt != 5'h1f);

    // Read data holds for a bounded time, then the bus is let go
    assign data_out = (cnt <= 5'h0c) ? {lat ^ 32'h5a5a_5a5a, lat}
                                     : {DATA_W{tgl}} ^ {lat, lat};
endmodule : cba_far_model

//--- testbench.sv
module testbench
    import cba_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [1:0]   sz;
        logic         wd;
        logic [2:0]   ws;
        logic         as;
        logic [31:0]  a;
        logic [127:0] q;
    } cba_row_s;

    localparam logic [2:0] MY_ID = 3'h5;
    // Size, wide device, wait states, async, address, packed word expected
    localparam cba_row_s ROWS [7] = '{
        '{SZ_32,  1'b0, 3'h0, 1'b0, 32'h0800_0100, 128'h0800_0100},
        '{SZ_64,  1'b0, 3'h1, 1'b0, 32'h0800_0110, 128'h0800_0111_0800_0110},
        '{SZ_128, 1'b0, 3'h2, 1'b0, 32'h0800_0120, 128'h0800_0123_0800_0122_0800_0121_0800_0120},
        '{SZ_64,  1'b1, 3'h0, 1'b0, 32'h0800_0200, 128'h525a_585a_0800_0200},
        '{SZ_128, 1'b1, 3'h7, 1'b0, 32'h0800_0300, 128'h525a_5958_0800_0302_525a_595a_0800_0300},
        '{SZ_64,  1'b1, 3'h0, 1'b1, 32'h0800_0400, 128'h525a_5e5a_0800_0400},
        '{SZ_128, 1'b0, 3'h0, 1'b1, 32'h0800_0500, 128'h0800_0503_0800_0502_0800_0501_0800_0500}
    };

    logic         clk, rst_n, host_n, lock, t_wr_n, t_rd_n, t_burst_indicator_n, t_drv;
    logic         c_rd, c_wr, c_wd, c_use, as_m;
    logic [7:0]   peer_n;
    logic [2:0]   ws;
    logic [1:0]   c_sz;
    logic [31:0]  t_addr, c_addr;
    logic [63:0]  t_data;
    logic [127:0] c_wdata;
    wire          req_o, gnt_n, a_oe_n, d_oe_n, wr_o, rd_o, c_oe_n, b_o, busy, stall;
    wire          rvalid, virq, ack, wr_w, rd_w, b_w;
    wire [31:0]   a_o, vdata, m_wa, addr_w;
    wire [63:0]   d_o, m_d, m_wd, data_w;
    wire [127:0]  rdata;
    wire [7:0]    breq;
    int           err_total, n_tests;

    // Shared lines: whoever has its enable low drives, else the outside side
    assign breq   = {peer_n[7:6], req_o, peer_n[4:0]};
    assign addr_w = a_oe_n ? t_addr : a_o;
    assign data_w = !d_oe_n ? d_o : (t_drv ? t_data : m_d);
    assign wr_w   = c_oe_n ? t_wr_n : wr_o;
    assign rd_w   = c_oe_n ? t_rd_n : rd_o;
    assign b_w    = c_oe_n ? t_burst_indicator_n : b_o;

    cba_arbiter i_dut (
        .REF_CLK_IN(clk), .RESET_N_IN(rst_n), .PROC_ID_IN(MY_ID), .BUS_REQ_N_IN(breq),
        .BUS_REQ_N_OUT(req_o), .HOST_BUS_REQUEST_N_IN(host_n), .HOST_BUS_GRANT_N_OUT(gnt_n),
        .LOCK_IN(lock), .ADDR_IN(addr_w), .ADDR_OUT(a_o), .ADDR_OE_N_OUT(a_oe_n),
        .DATA_IN(data_w), .DATA_OUT(d_o), .DATA_OE_N_OUT(d_oe_n), .WR_N_IN(wr_w),
        .RD_N_IN(rd_w), .WR_N_OUT(wr_o), .RD_N_OUT(rd_o), .CTRL_OE_N_OUT(c_oe_n),
        .BURST_INDICATOR_N_IN(b_w), .BURST_INDICATOR_N_OUT(b_o), .WAIT_STATES_IN(ws),
        .ASYNC_MODE_IN(as_m), .SLOW_ACK_IN(ack), .CORE_RD_IN(c_rd), .CORE_WR_IN(c_wr),
        .CORE_SIZE_IN(c_sz), .CORE_WIDE_DEV_IN(c_wd), .CORE_ADDR_IN(c_addr),
        .CORE_WDATA_IN(c_wdata), .CORE_USE_IN(c_use), .CORE_BUSY_OUT(busy),
        .CORE_STALL_OUT(stall), .CORE_RDATA_OUT(rdata), .CORE_RDATA_VALID_OUT(rvalid),
        .VEC_IRQ_OUT(virq), .VEC_DATA_OUT(vdata)
    );

    cba_far_model i_far (
        .clk_in(clk), .rst_n_in(rst_n), .addr_oe_n_in(a_oe_n), .rd_n_in(rd_o),
        .wr_n_in(wr_o), .addr_in(a_o), .data_in(d_o), .ws_in(ws), .ack_out(ack),
        .data_out(m_d), .wr_addr_out(m_wa), .wr_data_out(m_wd)
    );

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = !clk;
    end

    task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    // Polls valid, grant or busy at falling edges; running out ends the run
    task automatic wait_for(input int which, input logic lvl, input int max);
        logic v;
        n_tests++;
        for (int i = 0; i < max; i++) begin
            @(negedge clk);
            v = (which == 0) ? rvalid : (which == 1) ? gnt_n : busy;
            if (v === lvl) return;
        end
        err_total++;
        $display("Error wait %0d expected %b seen timeout", which, lvl);
        wrap_up();
    endtask : wait_for

    // One strobe cycle from an outside master; the next call may follow at once
    task automatic slv(input logic wr, input logic [31:0] a, input logic [63:0] d,
                       input logic bn);
        {t_addr, t_data, t_drv, t_wr_n, t_rd_n, t_burst_indicator_n} = {a, d, wr, !wr, wr, bn};
        @(negedge clk);
    endtask : slv

    task automatic idle();
        {t_wr_n, t_rd_n, t_burst_indicator_n, t_drv} = 4'b1110;
        t_addr = ~t_addr;
        @(negedge clk);
    endtask : idle

    // Core read request; the core then wants the target and must stall
    task automatic cissue(input cba_row_s r);
        @(negedge clk);
        {c_sz, c_wd, ws, as_m, c_addr} = {r.sz, r.wd, r.ws, r.as, r.a};
        c_rd  = 1'b1;
        c_use = 1'b1;
        @(negedge clk);
        c_rd = 1'b0;
        chk("stall", stall, 1'b1);
    endtask : cissue

    task automatic cfin(input cba_row_s r);
        logic [127:0] m;
        m = (r.sz == SZ_32) ? 128'hffff_ffff : (r.sz == SZ_64) ? {64'h0, {64{1'b1}}} : '1;
        wait_for(0, 1'b1, 200);
        chk("rdata", rdata & m, r.q);
        c_use = 1'b0;
    endtask : cfin

    initial begin
        err_total = 0;
        n_tests   = 0;
        {rst_n, host_n, lock, t_wr_n, t_rd_n, t_burst_indicator_n, t_drv} = 7'b0101110;
        {c_rd, c_wr, c_wd, c_use, as_m} = 5'b00000;
        {peer_n, ws, c_sz, t_addr, c_addr, t_data, c_wdata} = {8'hff, 261'h0};
        repeat (6) @(negedge clk);
        chk("reset", {gnt_n, req_o, a_oe_n, d_oe_n, c_oe_n, busy, rvalid, virq}, 8'hf8);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        foreach (ROWS[i]) begin
            cissue(ROWS[i]);
            cfin(ROWS[i]);
        end
        // Slave side: own window, broadcast, foreign id, vector, burst
        slv(1'b1, 32'h0340_0006, 64'h0123_4567_89ab_cdef, 1'b1);
        slv(1'b1, 32'h01c0_0008, 64'h0bad_cafe_0000_0008, 1'b1);
        slv(1'b1, 32'h0280_0006, 64'hffff_0000_ffff_0000, 1'b1);
        slv(1'b1, 32'h0360_000a, 64'h0000_0000_1234_5678, 1'b1);
        chk("virq", {virq, vdata}, {1'b1, 32'h1234_5678});
        slv(1'b1, 32'h0340_0010, 64'haaaa, 1'b0);
        slv(1'b1, 32'h0000_0000, 64'hbbbb, 1'b1);
        slv(1'b0, 32'h0340_0006, '0, 1'b1);
        chk("own rd", {d_oe_n, d_o}, {1'b0, 64'h0123_4567_89ab_cdef});
        slv(1'b0, 32'h0340_0008, '0, 1'b1);
        chk("bcast", {d_oe_n, d_o}, {1'b0, 64'h0bad_cafe_0000_0008});
        slv(1'b0, 32'h0340_0012, '0, 1'b1);
        chk("burst", {d_oe_n, d_o}, {1'b0, 64'hbbbb});
        slv(1'b0, 32'h0280_0006, '0, 1'b1);
        chk("foreign", d_oe_n, 1'b1);
        slv(1'b0, 32'h01c0_0008, '0, 1'b1);
        chk("bc rd", d_oe_n, 1'b1);
        idle();
        // One wide word written by the core reaches the far side intact
        {c_sz, c_wd, ws, as_m, c_addr} = {SZ_64, 1'b1, 3'h1, 1'b0, 32'h0800_0600};
        c_wdata = {64'h0, 64'h1122_3344_5566_7788};
        c_wr    = 1'b1;
        @(negedge clk);
        c_wr = 1'b0;
        wait_for(2, 1'b0, 60);
        chk("wr", {m_wa, m_wd}, {32'h0800_0600, 64'h1122_3344_5566_7788});
        // Host holds the bus while our read waits, then hands it back
        host_n = 1'b0;
        wait_for(1, 1'b0, 4);
        cissue(ROWS[0]);
        repeat (8) begin
            @(negedge clk);
            chk("hold", a_oe_n, 1'b1);
        end
        host_n = 1'b1;
        wait_for(1, 1'b1, 4);
        cfin(ROWS[0]);
        // A locked owner keeps the bus from the host until it unlocks
        lock = 1'b1;
        cissue(ROWS[3]);
        cfin(ROWS[3]);
        host_n = 1'b0;
        repeat (6) begin
            @(negedge clk);
            chk("lock", gnt_n, 1'b1);
        end
        lock = 1'b0;
        wait_for(1, 1'b0, 12);
        // Reset in mid-grant drops the grant at once
        rst_n = 1'b0;
        #1;
        chk("rst", {gnt_n, busy}, 2'b10);
        @(negedge clk);
        rst_n = 1'b1;
        wait_for(1, 1'b0, 6);
        host_n = 1'b1;
        wait_for(1, 1'b1, 4);
        // Two peers hand over back to back so the turn must rotate
        peer_n = 8'hfb;
        repeat (2) @(negedge clk);
        peer_n = 8'hf7;
        repeat (2) @(negedge clk);
        peer_n = 8'hff;
        wrap_up();
    end
endmodule : testbench
